/* rtl/scp_defines.svh */
/*
  Constants of the SCSI parity block: offsets, bit positions, sizes.
  Assumes inclusion by bare name.
*/
`ifndef SCP_DEFINES_SVH
`define SCP_DEFINES_SVH

// **********
// Register offsets (4-bit address, 8-bit data)
// **********
`define SCP_OFS_SCSI_CTRL_A 4'h0
`define SCP_OFS_SCSI_CTRL_B 4'h1
`define SCP_OFS_SCSI_IRQ_ENABLE_A 4'h2
`define SCP_OFS_SCSI_IRQ_STATUS_A 4'h3
`define SCP_OFS_SCSI_STAT_A 4'h4
`define SCP_OFS_SCSI_STAT_B 4'h5
`define SCP_OFS_SCSI_STAT_C 4'h6
`define SCP_OFS_CHIP_TEST_A 4'h7
`define SCP_OFS_CHIP_TEST_C 4'h8
`define SCP_OFS_CHIP_TEST_E 4'h9
`define SCP_OFS_DMA_FIFO_TEST_PORT 4'ha
`define SCP_OFS_SCSI_TEST_B 4'hb
`define SCP_OFS_SCSI_TEST_D 4'hc
`define SCP_OFS_SCSI_OUTPUT_DATA_LATCH 4'hd

// **********
// Bit positions
// **********
`define SCP_BIT_ATN_ON_PAR 1
`define SCP_BIT_PARITY_GEN_EN 2
`define SCP_BIT_PARITY_CHECK_EN 3
`define SCP_BIT_EVEN_PARITY_SEL 2
`define SCP_BIT_HALT_ON_PARITY_CTL 5
`define SCP_BIT_PARITY_IRQ_EN 0
`define SCP_BIT_PARITY_ERR 0
`define SCP_BIT_LIVE_PAR 0
`define SCP_BIT_LATCHED_PAR 3
`define SCP_BIT_DMA_FIFO_PAR 3
`define SCP_BIT_REGEN_RX_PAR 4
`define SCP_BIT_HOST_PAR_CHECK 3
`define SCP_BIT_SCSI_FIFO_PAR 0
`define SCP_BIT_SCSI_FIFO_TEST 0

// **********
// Reset values and sizes
// **********
`define SCP_RST_BYTE 8'h00
`define SCP_DMA_LANES 4
`define SCP_DMA_DEPTH 24
`define SCP_SFIFO_DEPTH 8

`endif

/* rtl/scp_pkg.sv */
/*
  Types shared by the SCSI parity control block.
  Assumes scp_defines.svh is on the include path.
*/
`default_nettype none

package scp_pkg;

  // **********
  // A byte together with its parity bit
  // **********
  typedef struct packed {
    logic par;
    logic [7:0] data;
  } scp_pbyte_s;

  // Transfer direction seen from the SCSI bus
  typedef enum logic {
    SCP_RECEIVE,
    SCP_SEND
  } scp_dir_e;

endpackage

`default_nettype wire

/* rtl/scp_parity_ctrl.sv */
/*
  SCSI parity control: parity generation, pass-through and checking between
  a 32-bit host data path with four byte parity lines and a 16-bit SCSI bus
  with low and high parity lines; parity error status, ATN, halt and
  interrupt signalling; parity lanes of the DMA FIFO and SCSI FIFO test access.
  Assumes host-side inputs come from logic on clk_i; SCSI pins are async and
  are synchronised here. Registers are reached over a plain strobe port.
*/
`include "scp_defines.svh"
`default_nettype none

// Contract
// - Initiator with ATN-on-parity set asserts ATN on any SCSI or host parity error.
// - Generation enabled computes SCSI parity; disabled passes parity through.
// - Checking disabled means no parity error is ever reported.
// - Checking with generation checks received SCSI bytes for odd parity.
// - Checking without generation checks SCSI data, and host data with the host-parity-check bit set, for odd parity.
// - Even-parity select drives even SCSI parity, else odd, in every mode; in pass-through the code only inverts the passed host parity when set.
// - Pass-through carries host parity lines to SCSI and SCSI parity back.
// - Generation ignores host parity lines and leaves them undriven on receive.
// - Pass-through regenerate bit replaces received SCSI parity with new parity.
// - Host-parity-check bit, generation off, checks host data taken in.
// - Parity error status bit sets on any detected SCSI or host error.
// - Interrupt on parity error only with enable set, both modes.
// - Halt-on-parity set halts in target mode only; clear never halts.
// - Halt and interrupt decisions are made independently.
// - Initiator parity interrupt waits until the block move completes.
// - Live SCSI low and high parity read as bit 0 of two status registers.
// - Input-latch parity of low and high bytes reads as bit 3.
// - DMA FIFO test port read exposes popped entry parity in a status bit.
// - DMA FIFO test port write stores the write-only test bit as parity.
// - With SCSI FIFO test access, output-latch reads pop it and show parity.
// - DMA FIFO is four 9-bit byte lanes, twenty-four entries deep.
module scp_parity_ctrl #(
  parameter int DMA_DEPTH = `SCP_DMA_DEPTH,
  parameter int SFIFO_DEPTH = `SCP_SFIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Operating mode from the sequencer
  input wire logic initiator_i,
  input wire scp_pkg::scp_dir_e dir_i,
  input wire logic tx_hi_sel_i,
  input wire logic block_move_done_i,
  // Host data path
  input wire logic host_valid_i,
  input wire logic [31:0] host_data_i,
  input wire logic [3:0] host_parity_lines_i,
  output logic [31:0] host_rx_data_o,
  output logic [3:0] host_parity_lines_o,
  output logic [3:0] host_parity_lines_oe_o,
  // SCSI bus data and parity
  input wire logic [15:0] scsi_data_i,
  input wire logic scsi_parity_low_i,
  input wire logic scsi_parity_high_i,
  input wire logic scsi_rx_strobe_i,
  output logic [15:0] scsi_data_o,
  output logic scsi_parity_low_o,
  output logic scsi_parity_high_o,
  output logic scsi_oe_o,
  // Error reactions
  output logic atn_o,
  output logic halt_o,
  output logic parity_irq_o
);

  localparam int DMA_ENTRIES = `SCP_DMA_LANES * DMA_DEPTH;
  localparam int SPW = $clog2(SFIFO_DEPTH);

  // **********
  // State
  // **********
  typedef struct packed {
    logic atn_en;
    logic gen_en;
    logic chk_en;
    logic even_sel;
    logic halt_ctl;
    logic irq_en;
    logic par_err;
    logic regen;
    logic fifo_par_wr;
    logic dma_par_rd;
    logic host_chk;
    logic sfifo_test;
    logic sfifo_par_rd;
    logic [15:0] sync_data_a;
    logic [15:0] sync_data_b;
    logic [1:0] sync_par_a;
    logic [1:0] sync_par_b;
    logic sync_stb_a;
    logic sync_stb_b;
    logic stb_prev;
    logic [15:0] in_latch;
    logic [1:0] in_par;
    logic [15:0] tx_data;
    logic [1:0] tx_par;
    logic tx_oe;
    logic [31:0] host_rx;
    logic [3:0] host_par;
    logic [3:0] host_par_oe;
    logic atn;
    logic halt;
    logic irq;
    logic irq_pend;
    logic [7:0] rdata;
    scp_pkg::scp_pbyte_s [`SCP_DMA_LANES-1:0][DMA_DEPTH-1:0] dma_mem;
    logic [6:0] dma_wr_idx;
    logic [6:0] dma_rd_idx;
    logic [6:0] dma_cnt;
    scp_pkg::scp_pbyte_s [SFIFO_DEPTH-1:0] sfifo_mem;
    logic [SPW-1:0] sfifo_wr;
    logic [SPW-1:0] sfifo_rd;
    logic [SPW:0] sfifo_cnt;
  } scp_state_s;

  scp_state_s state_ff;
  scp_state_s nxt_state;

  // **********
  // Helpers
  // **********
  // Parity bit to drive for a byte in the selected sense
  function automatic logic scp_gen_par(input logic [7:0] b, input logic even);
    scp_gen_par = (~^b) ^ even;
  endfunction

  // High when a byte and its parity fail the odd check
  function automatic logic scp_odd_bad(input logic [7:0] b, input logic p);
    scp_odd_bad = ~(^{b, p});
  endfunction

  // Next DMA FIFO slot: lanes fill first, then the entry moves on
  function automatic logic [6:0] scp_dma_next(input logic [6:0] idx);
    logic [1:0] lane;
    logic [4:0] ent;
    lane = idx[6:5];
    ent = idx[4:0];
    if (lane == 2'(`SCP_DMA_LANES - 1)) begin
      lane = 2'h0;
      ent = (ent == 5'(DMA_DEPTH - 1)) ? 5'h00 : ent + 5'h01;
    end else begin
      lane = lane + 2'h1;
    end
    scp_dma_next = {lane, ent};
  endfunction

  // **********
  // Combinational next state
  // **********
  logic rx_event;
  logic scsi_err;
  logic host_err;
  logic par_err_now;
  logic host_chk_active;
  logic [15:0] tx_word;
  logic [1:0] tx_hpar;
  logic [1:0] rx_gen_par;
  logic status_clear;
  logic dma_wr;
  logic dma_rd;
  logic sfifo_pop;
  logic sfifo_push;
  scp_pkg::scp_pbyte_s dma_rd_entry;

  always_comb begin
    nxt_state = state_ff;
    // Second stage only feeds logic, the first never does
    nxt_state.sync_data_a = scsi_data_i;
    nxt_state.sync_data_b = state_ff.sync_data_a;
    nxt_state.sync_par_a = {scsi_parity_high_i, scsi_parity_low_i};
    nxt_state.sync_par_b = state_ff.sync_par_a;
    nxt_state.sync_stb_a = scsi_rx_strobe_i;
    nxt_state.sync_stb_b = state_ff.sync_stb_a;
    nxt_state.stb_prev = state_ff.sync_stb_b;
    rx_event = state_ff.sync_stb_b & ~state_ff.stb_prev;

    // Error detection, all gated by the checking enable
    scsi_err = state_ff.chk_en & rx_event &
               (scp_odd_bad(state_ff.sync_data_b[7:0], state_ff.sync_par_b[0]) |
                scp_odd_bad(state_ff.sync_data_b[15:8], state_ff.sync_par_b[1]));
    host_chk_active = state_ff.chk_en & ~state_ff.gen_en & state_ff.host_chk;
    host_err = 1'b0;
    for (int i = 0; i < 4; i++) begin
      host_err = host_err |
                 scp_odd_bad(host_data_i[8*i +: 8], host_parity_lines_i[i]);
    end
    host_err = host_err & host_valid_i & host_chk_active;
    par_err_now = scsi_err | host_err;

    // Send path: generate or pass through, then apply the sense
    tx_word = tx_hi_sel_i ? host_data_i[31:16] : host_data_i[15:0];
    tx_hpar = tx_hi_sel_i ? host_parity_lines_i[3:2] : host_parity_lines_i[1:0];
    nxt_state.tx_oe = (dir_i == scp_pkg::SCP_SEND);
    if (host_valid_i && dir_i == scp_pkg::SCP_SEND) begin
      nxt_state.tx_data = tx_word;
      if (state_ff.gen_en) begin
        // Host lines ignored while generating
        nxt_state.tx_par[0] = scp_gen_par(tx_word[7:0], state_ff.even_sel);
        nxt_state.tx_par[1] = scp_gen_par(tx_word[15:8], state_ff.even_sel);
      end else begin
        // Sense select also flips passed parity, which lets bad parity be sent
        nxt_state.tx_par = tx_hpar ^ {2{state_ff.even_sel}};
      end
    end

    // Receive path: input latch and parity back to the host lanes
    rx_gen_par[0] = scp_gen_par(state_ff.sync_data_b[7:0], 1'b0);
    rx_gen_par[1] = scp_gen_par(state_ff.sync_data_b[15:8], 1'b0);
    if (rx_event) begin
      nxt_state.in_latch = state_ff.sync_data_b;
      nxt_state.in_par = state_ff.sync_par_b;
      nxt_state.host_rx = {state_ff.sync_data_b, state_ff.sync_data_b};
      if (state_ff.regen) begin
        nxt_state.host_par = {rx_gen_par, rx_gen_par};
      end else begin
        nxt_state.host_par = {state_ff.sync_par_b, state_ff.sync_par_b};
      end
    end
    // Lines driven only in pass-through while receiving
    nxt_state.host_par_oe = {4{~state_ff.gen_en & (dir_i == scp_pkg::SCP_RECEIVE)}};

    // Error reactions
    status_clear = reg_wr_i && reg_addr_i == `SCP_OFS_SCSI_IRQ_STATUS_A &&
                   reg_wdata_i[`SCP_BIT_PARITY_ERR];
    if (status_clear) begin
      nxt_state.par_err = 1'b0;
      nxt_state.atn = 1'b0;
      nxt_state.irq = 1'b0;
      nxt_state.irq_pend = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (par_err_now) begin
      nxt_state.par_err = 1'b1;
    end
    if (par_err_now && initiator_i && state_ff.atn_en) begin
      nxt_state.atn = 1'b1;
    end
    nxt_state.halt = par_err_now & ~initiator_i & state_ff.halt_ctl;
    if (par_err_now && state_ff.irq_en) begin
      if (initiator_i) begin
        nxt_state.irq_pend = 1'b1;
      end else begin
        nxt_state.irq = 1'b1;
      end
    end
    // Deferred initiator interrupt released at the end of the move
    if (state_ff.irq_pend && block_move_done_i) begin
      nxt_state.irq = 1'b1;
      nxt_state.irq_pend = 1'b0;
    end

    // SCSI FIFO fills from received low bytes
    sfifo_push = rx_event && (state_ff.sfifo_cnt != (SPW+1)'(SFIFO_DEPTH));
    sfifo_pop = reg_rd_i && reg_addr_i == `SCP_OFS_SCSI_OUTPUT_DATA_LATCH &&
                state_ff.sfifo_test && state_ff.sfifo_cnt != '0;
    if (sfifo_push) begin
      nxt_state.sfifo_mem[state_ff.sfifo_wr] = {state_ff.sync_par_b[0],
                                                state_ff.sync_data_b[7:0]};
      nxt_state.sfifo_wr = state_ff.sfifo_wr + SPW'(1);
    end
    if (sfifo_pop) begin
      nxt_state.sfifo_par_rd = state_ff.sfifo_mem[state_ff.sfifo_rd].par;
      nxt_state.sfifo_rd = state_ff.sfifo_rd + SPW'(1);
    end
    nxt_state.sfifo_cnt = state_ff.sfifo_cnt + (SPW+1)'(sfifo_push) - (SPW+1)'(sfifo_pop);

    // DMA FIFO test port, one byte lane per access
    dma_wr = reg_wr_i && reg_addr_i == `SCP_OFS_DMA_FIFO_TEST_PORT &&
             state_ff.dma_cnt != 7'(DMA_ENTRIES);
    dma_rd = reg_rd_i && reg_addr_i == `SCP_OFS_DMA_FIFO_TEST_PORT &&
             state_ff.dma_cnt != 7'h00;
    dma_rd_entry = state_ff.dma_mem[state_ff.dma_rd_idx[6:5]][state_ff.dma_rd_idx[4:0]];
    if (dma_wr) begin
      nxt_state.dma_mem[state_ff.dma_wr_idx[6:5]][state_ff.dma_wr_idx[4:0]] =
        {state_ff.fifo_par_wr, reg_wdata_i};
      nxt_state.dma_wr_idx = scp_dma_next(state_ff.dma_wr_idx);
    end
    if (dma_rd) begin
      nxt_state.dma_par_rd = dma_rd_entry.par;
      nxt_state.dma_rd_idx = scp_dma_next(state_ff.dma_rd_idx);
    end
    nxt_state.dma_cnt = state_ff.dma_cnt + 7'(dma_wr) - 7'(dma_rd);

    // Register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        `SCP_OFS_SCSI_CTRL_A: begin
          nxt_state.atn_en = reg_wdata_i[`SCP_BIT_ATN_ON_PAR];
          nxt_state.gen_en = reg_wdata_i[`SCP_BIT_PARITY_GEN_EN];
          nxt_state.chk_en = reg_wdata_i[`SCP_BIT_PARITY_CHECK_EN];
        end
        `SCP_OFS_SCSI_CTRL_B: begin
          nxt_state.even_sel = reg_wdata_i[`SCP_BIT_EVEN_PARITY_SEL];
          nxt_state.halt_ctl = reg_wdata_i[`SCP_BIT_HALT_ON_PARITY_CTL];
        end
        `SCP_OFS_SCSI_IRQ_ENABLE_A: begin
          nxt_state.irq_en = reg_wdata_i[`SCP_BIT_PARITY_IRQ_EN];
        end
        `SCP_OFS_CHIP_TEST_A: begin
          nxt_state.fifo_par_wr = reg_wdata_i[`SCP_BIT_DMA_FIFO_PAR];
          nxt_state.regen = reg_wdata_i[`SCP_BIT_REGEN_RX_PAR];
        end
        `SCP_OFS_CHIP_TEST_E: begin
          nxt_state.host_chk = reg_wdata_i[`SCP_BIT_HOST_PAR_CHECK];
        end
        `SCP_OFS_SCSI_TEST_D: begin
          nxt_state.sfifo_test = reg_wdata_i[`SCP_BIT_SCSI_FIFO_TEST];
        end
        default: begin
        end
      endcase
    end

    // Register reads, data valid only in the following cycle
    nxt_state.rdata = `SCP_RST_BYTE;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `SCP_OFS_SCSI_CTRL_A: begin
          nxt_state.rdata[`SCP_BIT_ATN_ON_PAR] = state_ff.atn_en;
          nxt_state.rdata[`SCP_BIT_PARITY_GEN_EN] = state_ff.gen_en;
          nxt_state.rdata[`SCP_BIT_PARITY_CHECK_EN] = state_ff.chk_en;
        end
        `SCP_OFS_SCSI_CTRL_B: begin
          nxt_state.rdata[`SCP_BIT_EVEN_PARITY_SEL] = state_ff.even_sel;
          nxt_state.rdata[`SCP_BIT_HALT_ON_PARITY_CTL] = state_ff.halt_ctl;
        end
        `SCP_OFS_SCSI_IRQ_ENABLE_A: begin
          nxt_state.rdata[`SCP_BIT_PARITY_IRQ_EN] = state_ff.irq_en;
        end
        `SCP_OFS_SCSI_IRQ_STATUS_A: begin
          nxt_state.rdata[`SCP_BIT_PARITY_ERR] = state_ff.par_err;
        end
        `SCP_OFS_SCSI_STAT_A: begin
          nxt_state.rdata[`SCP_BIT_LIVE_PAR] = state_ff.sync_par_b[0];
        end
        `SCP_OFS_SCSI_STAT_B: begin
          nxt_state.rdata[`SCP_BIT_LATCHED_PAR] = state_ff.in_par[0];
        end
        `SCP_OFS_SCSI_STAT_C: begin
          nxt_state.rdata[`SCP_BIT_LIVE_PAR] = state_ff.sync_par_b[1];
          nxt_state.rdata[`SCP_BIT_LATCHED_PAR] = state_ff.in_par[1];
        end
        `SCP_OFS_CHIP_TEST_A: begin
          // Parity test bit is write-only
          nxt_state.rdata[`SCP_BIT_REGEN_RX_PAR] = state_ff.regen;
        end
        `SCP_OFS_CHIP_TEST_C: begin
          nxt_state.rdata[`SCP_BIT_DMA_FIFO_PAR] = state_ff.dma_par_rd;
        end
        `SCP_OFS_CHIP_TEST_E: begin
          nxt_state.rdata[`SCP_BIT_HOST_PAR_CHECK] = state_ff.host_chk;
        end
        `SCP_OFS_DMA_FIFO_TEST_PORT: begin
          nxt_state.rdata = dma_rd ? dma_rd_entry.data : `SCP_RST_BYTE;
        end
        `SCP_OFS_SCSI_TEST_B: begin
          nxt_state.rdata[`SCP_BIT_SCSI_FIFO_PAR] = state_ff.sfifo_par_rd;
        end
        `SCP_OFS_SCSI_TEST_D: begin
          nxt_state.rdata[`SCP_BIT_SCSI_FIFO_TEST] = state_ff.sfifo_test;
        end
        `SCP_OFS_SCSI_OUTPUT_DATA_LATCH: begin
          nxt_state.rdata = sfifo_pop ? state_ff.sfifo_mem[state_ff.sfifo_rd].data :
                            state_ff.tx_data[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // **********
  // State register
  // **********
  // Whole state cleared by chip reset, FIFO contents included
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // **********
  // Outputs
  // **********
  // All outputs come straight from state flip-flops
  assign reg_rdata_o = state_ff.rdata;
  assign host_rx_data_o = state_ff.host_rx;
  assign host_parity_lines_o = state_ff.host_par;
  assign host_parity_lines_oe_o = state_ff.host_par_oe;
  assign scsi_data_o = state_ff.tx_data;
  assign scsi_parity_low_o = state_ff.tx_par[0];
  assign scsi_parity_high_o = state_ff.tx_par[1];
  assign scsi_oe_o = state_ff.tx_oe;
  assign atn_o = state_ff.atn;
  assign halt_o = state_ff.halt;
  assign parity_irq_o = state_ff.irq;

endmodule

`default_nettype wire

/* test/scp_parity_ctrl_monitor.sv */
/* Checker of the parity control ports: error reactions and send parity.
   Assumes binding to scp_parity_ctrl; control bits are shadowed from writes. */
`default_nettype none
module scp_parity_ctrl_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Register writes
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Mode and host side
  input wire logic initiator_i,
  input wire scp_pkg::scp_dir_e dir_i,
  input wire logic tx_hi_sel_i,
  input wire logic block_move_done_i,
  input wire logic host_valid_i,
  input wire logic [31:0] host_data_i,
  input wire logic [3:0] host_parity_lines_i,
  // Watched outputs
  input wire logic [3:0] host_parity_lines_oe_o,
  input wire logic scsi_parity_low_o,
  input wire logic atn_o,
  input wire logic halt_o,
  input wire logic parity_irq_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] ca_ff, cb_ff;
  logic ie_ff, clr, snd_g, snd_p, exp_lo;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Shadow control bits, same edge as the block's copy
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ca_ff <= 8'h00;
      cb_ff <= 8'h00;
      ie_ff <= 1'b0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 4'h0) ca_ff <= reg_wdata_i;
      if (reg_addr_i == 4'h1) cb_ff <= reg_wdata_i;
      if (reg_addr_i == 4'h2) ie_ff <= reg_wdata_i[0];
    end
  end
  // Expected low send parity, chosen lane, sense applied last
  assign clr = reg_wr_i && reg_addr_i == 4'h3 && reg_wdata_i[0];
  assign snd_g = host_valid_i && dir_i == scp_pkg::SCP_SEND && ca_ff[2];
  assign snd_p = host_valid_i && dir_i == scp_pkg::SCP_SEND && !ca_ff[2];
  assign exp_lo = cb_ff[2] ^ (ca_ff[2] ?
    ~^(tx_hi_sel_i ? host_data_i[23:16] : host_data_i[7:0]) :
    (tx_hi_sel_i ? host_parity_lines_i[2] : host_parity_lines_i[0]));
  property p_oe_rx;
    (|host_parity_lines_oe_o) |-> !$past(ca_ff[2]) && $past(dir_i) == scp_pkg::SCP_RECEIVE;
  endproperty
  a_oe_rx: assert property (p_oe_rx) else $error("host parity driven while generating");
  property p_atn;
    $rose(atn_o) |-> $past(initiator_i) && $past(ca_ff[1]) && $past(ca_ff[3]);
  endproperty
  a_atn: assert property (p_atn) else $error("attention raised without cause");
  property p_irq;
    $rose(parity_irq_o) |-> $past(ie_ff) && $past(ca_ff[3]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt raised while disabled");
  property p_irq_init;
    $rose(parity_irq_o) && $past(initiator_i) |-> $past(block_move_done_i);
  endproperty
  a_irq_init: assert property (p_irq_init) else $error("initiator interrupt early");
  property p_halt;
    halt_o |-> !$past(initiator_i) && $past(cb_ff[5]) && $past(ca_ff[3]);
  endproperty
  a_halt: assert property (p_halt) else $error("halt outside target mode");
  property p_atn_hold;
    atn_o && !clr |=> atn_o;
  endproperty
  a_atn_hold: assert property (p_atn_hold) else $error("attention dropped early");
  property p_irq_hold;
    parity_irq_o && !clr |=> parity_irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt dropped early");
  property p_tx_gen;
    $past(snd_g) |-> scsi_parity_low_o == $past(exp_lo);
  endproperty
  a_tx_gen: assert property (p_tx_gen) else $error("generated parity wrong");
  property p_tx_pass;
    $past(snd_p) |-> scsi_parity_low_o == $past(exp_lo);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("passed parity wrong");
  // Main scenarios reached
  c_halt: cover property (halt_o);
  c_atn: cover property ($rose(atn_o));
  c_irq_init: cover property (initiator_i && $rose(parity_irq_o));
endmodule
bind scp_parity_ctrl scp_parity_ctrl_monitor u_scp_parity_ctrl_monitor (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .initiator_i(initiator_i), .dir_i(dir_i), .tx_hi_sel_i(tx_hi_sel_i),
  .block_move_done_i(block_move_done_i), .host_valid_i(host_valid_i),
  .host_data_i(host_data_i), .host_parity_lines_i(host_parity_lines_i),
  .host_parity_lines_oe_o(host_parity_lines_oe_o), .scsi_parity_low_o(scsi_parity_low_o),
  .atn_o(atn_o), .halt_o(halt_o), .parity_irq_o(parity_irq_o)
);
`default_nettype wire

/* test/scp_scsi_dev.sv */
/* Far SCSI device: sends one word with per-byte parity and a strobe.
   Assumes the bench calls send_word; pins show inverted values when idle. */
`default_nettype none
module scp_scsi_dev (
  // Clock
  input wire logic clk_i,
  // Pins toward the block
  output logic [15:0] data_o,
  output logic par_lo_o,
  output logic par_hi_o,
  output logic strobe_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    data_o = 16'h0000;
    par_lo_o = 1'b1;
    par_hi_o = 1'b1;
    strobe_o = 1'b0;
  end
  // Odd parity per byte unless a bad byte is ordered; hold sets the pace
  task automatic send_word(input logic [15:0] d, input logic bl, input logic bh, input int hold);
    @(posedge clk_i);
    data_o <= d;
    par_lo_o <= ~^d[7:0] ^ bl;
    par_hi_o <= ~^d[15:8] ^ bh;
    strobe_o <= 1'b1;
    repeat (hold) @(posedge clk_i);
    // Released pins invert, so a stale level never looks held
    data_o <= ~d;
    par_lo_o <= ~par_lo_o;
    par_hi_o <= ~par_hi_o;
    strobe_o <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

/* test/scp_parity_ctrl_tb_top.sv */
/* Bench of the parity control block: registers, host send, SCSI receive,
   DMA FIFO test port; expected values come from a model in the bench. */
`default_nettype none
`define CHK(x, y) begin checked++; if ((x) !== (y)) begin errors++; \
  $display("mismatch at %0t: got %h expected %h", $time, x, y); end end
module scp_parity_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic rst_b_i, reg_wr_i, reg_rd_i, initiator_i, tx_hi_sel_i, block_move_done_i, host_valid_i;
  logic [3:0] reg_addr_i, host_parity_lines_i, hp_o, hp_oe;
  logic [7:0] reg_wdata_i, reg_rdata_o, d, t;
  scp_pkg::scp_dir_e dir_i;
  logic [31:0] host_data_i, rx_o, r;
  logic [15:0] sd_i, sd_o, w;
  logic pl_i, ph_i, strb, pl_o, ph_o, atn_o, halt_o, irq_o, pl, ph, err;
  logic [10:0] cfg;
  logic [8:0] v, q[$];
  int errors, checked, halts, h0;
  integer seed = 32'h5d15b8b0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (halt_o === 1'b1) halts++;
  scp_parity_ctrl u_scp_parity_ctrl (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .initiator_i(initiator_i), .dir_i(dir_i), .tx_hi_sel_i(tx_hi_sel_i),
    .block_move_done_i(block_move_done_i), .host_valid_i(host_valid_i), .host_data_i(host_data_i),
    .host_parity_lines_i(host_parity_lines_i), .host_rx_data_o(rx_o), .host_parity_lines_o(hp_o),
    .host_parity_lines_oe_o(hp_oe), .scsi_data_i(sd_i), .scsi_parity_low_i(pl_i),
    .scsi_parity_high_i(ph_i), .scsi_rx_strobe_i(strb), .scsi_data_o(sd_o),
    .scsi_parity_low_o(pl_o), .scsi_parity_high_o(ph_o), .scsi_oe_o(), .atn_o(atn_o),
    .halt_o(halt_o), .parity_irq_o(irq_o));
  scp_scsi_dev u_scp_scsi_dev (.clk_i(clk_i), .data_o(sd_i), .par_lo_o(pl_i), .par_hi_o(ph_i),
    .strobe_o(strb));
  // Register port: one-cycle strobes, read data in the following cycle only
  task automatic wr(input logic [3:0] a, input logic [7:0] x);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= x;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [3:0] a, input logic [7:0] m, input logic [7:0] x);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
    `CHK(d & m, x)
  endtask
  task automatic stop_test;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the expected few thousand cycles
  initial begin
    #500000;
    errors++;
    stop_test();
  end
  initial begin
    {reg_addr_i, reg_wdata_i, reg_wr_i, reg_rd_i, initiator_i, tx_hi_sel_i} = '0;
    {block_move_done_i, host_valid_i, host_data_i, host_parity_lines_i} = '0;
    dir_i = scp_pkg::SCP_RECEIVE;
    rst_b_i = 1'b0;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // Reset values, skipping pin-driven status; unmapped write is ignored
    wr(4'hf, 8'hff);
    for (int a = 0; a < 16; a++) if (a < 4 || a > 6) rc(4'(a), 8'hff, 8'h00);
    // Host send across generation, checking, sense and host check bits
    for (int i = 0; i < 48; i++) begin
      cfg = 11'($random(seed));
      r = $random(seed);
      wr(4'h0, {4'h0, cfg[1], cfg[0], 2'b00});
      wr(4'h1, {5'h00, cfg[2], 2'b00});
      wr(4'h9, {4'h0, cfg[3], 3'h0});
      wr(4'h3, 8'h01);
      @(posedge clk_i);
      dir_i <= scp_pkg::SCP_SEND;
      host_data_i <= r;
      host_parity_lines_i <= {~^r[31:24], ~^r[23:16], ~^r[15:8], ~^r[7:0]} ^ {4{cfg[4]}};
      tx_hi_sel_i <= cfg[5];
      host_valid_i <= 1'b1;
      @(posedge clk_i);
      host_valid_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      w = cfg[5] ? r[31:16] : r[15:0];
      pl = ~^w[7:0] ^ (cfg[4] & ~cfg[0]);
      ph = ~^w[15:8] ^ (cfg[4] & ~cfg[0]);
      `CHK(sd_o, w)
      `CHK({ph_o, pl_o}, {ph, pl} ^ {2{cfg[2]}})
      rc(4'h3, 8'h01, {7'h0, cfg[1] & ~cfg[0] & cfg[3] & cfg[4]});
    end
    // SCSI receive with random errors, modes and reactions
    for (int i = 0; i < 48; i++) begin
      cfg = 11'($random(seed));
      w = $random(seed);
      @(posedge clk_i);
      dir_i <= scp_pkg::SCP_RECEIVE;
      initiator_i <= cfg[6];
      wr(4'h0, {4'h0, cfg[1], cfg[0], 2'b10});
      wr(4'h1, {2'b00, cfg[8], 5'h00});
      wr(4'h2, {7'h0, cfg[7]});
      wr(4'h7, {3'h0, cfg[2], 4'h0});
      wr(4'h3, 8'h01);
      h0 = halts;
      pl = ~^w[7:0] ^ (cfg[3] & cfg[4]);
      ph = ~^w[15:8] ^ (cfg[3] & cfg[5]);
      err = cfg[1] & cfg[3] & (cfg[4] | cfg[5]);
      if (q.size() < 8) q.push_back({pl, w[7:0]});
      u_scp_scsi_dev.send_word(w, cfg[3] & cfg[4], cfg[3] & cfg[5], 4 + cfg[10:9]);
      `CHK(rx_o, {w, w})
      if (!cfg[0]) `CHK(hp_o, cfg[2] ? {2{~^w[15:8], ~^w[7:0]}} : {2{ph, pl}})
      `CHK(hp_oe, {4{~cfg[0]}})
      `CHK(atn_o, err & cfg[6])
      `CHK(irq_o, err & cfg[7] & ~cfg[6])
      `CHK(halts - h0, err & cfg[8] & ~cfg[6])
      rc(4'h3, 8'h01, {7'h0, err});
      rc(4'h5, 8'h08, {4'h0, pl, 3'h0});
      rc(4'h6, 8'h09, {4'h0, ph, 2'h0, ~ph});
      rc(4'h4, 8'h01, {7'h0, ~pl});
      @(posedge clk_i);
      block_move_done_i <= 1'b1;
      @(posedge clk_i);
      block_move_done_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK(irq_o, err & cfg[7])
      rc(4'h3, 8'h01, {7'h0, err});
    end
    // SCSI FIFO test access pops the first eight low bytes
    wr(4'hc, 8'h01);
    while (q.size() > 0) begin
      v = q.pop_front();
      rc(4'hd, 8'hff, v[7:0]);
      rc(4'hb, 8'h01, {7'h0, v[8]});
    end
    // DMA FIFO test port: fill 96 bytes, one more is dropped, drain in order
    for (int i = 0; i < 97; i++) begin
      v = 9'($random(seed));
      wr(4'h7, {4'h0, v[8], 3'h0});
      wr(4'ha, v[7:0]);
      if (i < 96) q.push_back(v);
    end
    while (q.size() > 0) begin
      v = q.pop_front();
      rc(4'ha, 8'hff, v[7:0]);
      rc(4'h8, 8'h08, {4'h0, v[8], 3'h0});
    end
    rc(4'ha, 8'hff, 8'h00);
    stop_test();
  end
endmodule
`undef CHK
`default_nettype wire
